/* File: inc/bmem_defines.vh */
// Constants for the sixteen-byte selectable fast memory
// Function
// - Sixteen locations, one byte each, 128 bits
// - Up to 32 modules share address lines
// - Every access moves a whole byte
// - Selected only when all five selects true
// - Deselected outputs sit all ones for wired-AND
// - Byte plus column address picks location, nondestructive
// - Write on write pulse trailing edge when selected, enabled
// - Write within 165 ns, read within 110 ns
`ifndef BMEM_DEFINES_VH
`define BMEM_DEFINES_VH
// ****************************************
// Geometry
// ****************************************
`define BMEM_DATA_W      8
`define BMEM_DEPTH       16
`define BMEM_ADDR_W      4
`define BMEM_BYTE_ADDR_W 3
`define BMEM_COL_ADDR_W  2
`define BMEM_SEL_W       5
`define BMEM_MAX_MODULES 32
// ****************************************
// Values
// ****************************************
`define BMEM_SEL_ALL     5'h1f
`define BMEM_IDLE_DATA   8'hff
`define BMEM_RESET_DATA  8'h00
`define BMEM_WRITE_PIN   1'h1
// ****************************************
// Timing
// ****************************************
`define BMEM_CLK_PERIOD_NS 8
`define BMEM_WRITE_MAX_NS  165
`define BMEM_READ_MAX_NS   110
`define BMEM_WRITE_CYCLES  (`BMEM_WRITE_MAX_NS / `BMEM_CLK_PERIOD_NS)
`define BMEM_READ_CYCLES   (`BMEM_READ_MAX_NS / `BMEM_CLK_PERIOD_NS)
`endif

/* File: rtl/bmem_edge.v */
// Two-flop synchroniser and trailing-edge detector for the write pulse
`timescale 1ns/100ps
`default_nettype none
module bmem_edge (
	input  wire clk_in,
	input  wire rst_n_in,
	input  wire pulse_in,
	output reg  fall_out
);
	reg meta;
	reg sync;
	reg prev;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta     <= 1'b0;
			sync     <= 1'b0;
			prev     <= 1'b0;
			fall_out <= 1'b0;
		end else begin
			meta     <= pulse_in;
			sync     <= meta;
			prev     <= sync;
			fall_out <= prev & ~sync;
		end
	end
endmodule // bmem_edge
`default_nettype wire

/* File: rtl/bmem_top.v */
// Sixteen-byte fast memory with five-line module select
`timescale 1ns/100ps
`default_nettype none
`include "bmem_defines.vh"
module bmem_top #(
	parameter DATA_W = `BMEM_DATA_W,
	parameter DEPTH  = `BMEM_DEPTH
) (
	input  wire                         clk_in,
	input  wire                         rst_n_in,
	input  wire [`BMEM_SEL_W-1:0]       module_sel_in,
	input  wire [`BMEM_BYTE_ADDR_W-1:0] byte_addr_in,
	input  wire [`BMEM_COL_ADDR_W-1:0]  col_addr_in,
	input  wire                         write_en_in,
	input  wire                         write_pulse_in,
	input  wire [DATA_W-1:0]            data_in,
	output reg  [DATA_W-1:0]            data_out
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	// Host lines are asynchronous pins, each passed through two flops.
	// They are held stable around the pulse, so one more register stage
	// keeps address, data, enable and select aligned with the edge pulse.
	reg  [`BMEM_SEL_W-1:0]       sel_meta;
	reg  [`BMEM_SEL_W-1:0]       sel_sync;
	reg  [`BMEM_COL_ADDR_W-1:0]  col_meta;
	reg  [`BMEM_COL_ADDR_W-1:0]  col_sync;
	reg  [`BMEM_BYTE_ADDR_W-1:0] byte_meta;
	reg  [`BMEM_BYTE_ADDR_W-1:0] byte_sync;

	wire                         col_hi;
	wire [`BMEM_ADDR_W-1:0]      addr_sync;
	reg  [`BMEM_ADDR_W-1:0]      addr_hold;
	reg  [DATA_W-1:0]            data_meta;
	reg  [DATA_W-1:0]            data_sync;
	reg  [DATA_W-1:0]            data_hold;

	reg                          we_meta;
	reg                          we_sync;
	reg                          we_hold;
	reg                          sel_hold;
	wire                         write_fall;
	wire                         write_go;
	wire [DEPTH-1:0]             write_hit;
	wire                         selected;

	reg  [DATA_W-1:0]            mem [0:DEPTH-1];
	reg  [DATA_W-1:0]            next_data;

	// ****************************************
	// Module select synchroniser
	// ****************************************
	// Lines are decoded only after both flops
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sel_meta <= {`BMEM_SEL_W{1'b0}};
			sel_sync <= {`BMEM_SEL_W{1'b0}};
		end else begin
			sel_meta <= module_sel_in;
			sel_sync <= sel_meta;
		end
	end

	// ****************************************
	// Column address synchroniser
	// ****************************************
	// Both lines kept apart until synchronised
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			col_meta <= {`BMEM_COL_ADDR_W{1'b0}};
			col_sync <= {`BMEM_COL_ADDR_W{1'b0}};
		end else begin
			col_meta <= col_addr_in;
			col_sync <= col_meta;
		end
	end

	// ****************************************
	// Byte address synchroniser
	// ****************************************
	// Low three bits of the location
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			byte_meta <= {`BMEM_BYTE_ADDR_W{1'b0}};
			byte_sync <= {`BMEM_BYTE_ADDR_W{1'b0}};
		end else begin
			byte_meta <= byte_addr_in;
			byte_sync <= byte_meta;
		end
	end

	// ****************************************
	// Write data synchroniser
	// ****************************************
	// Whole byte moves together
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_meta <= {DATA_W{1'b0}};
			data_sync <= {DATA_W{1'b0}};
		end else begin
			data_meta <= data_in;
			data_sync <= data_meta;
		end
	end

	// ****************************************
	// Write enable synchroniser
	// ****************************************
	// Enable must be held across the pulse by the host
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			we_meta <= 1'b0;
			we_sync <= 1'b0;
		end else begin
			we_meta <= write_en_in;
			we_sync <= we_meta;
		end
	end

	// ****************************************
	// Address and data hold stage
	// ****************************************
	// One stage more lines them up with the edge detector output
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_hold <= {`BMEM_ADDR_W{1'b0}};
			data_hold <= {DATA_W{1'b0}};
		end else begin
			addr_hold <= addr_sync;
			data_hold <= data_sync;
		end
	end

	// ****************************************
	// Control hold stage
	// ****************************************
	// Select and enable delayed one stage to line up with the detected edge
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			we_hold  <= 1'b0;
			sel_hold <= 1'b0;
		end else begin
			we_hold  <= we_sync;
			sel_hold <= selected;
		end
	end

	// ****************************************
	// Address and select decode
	// ****************************************
	// Either column line high picks the upper eight bytes, so a host
	// that drives only one column line still reaches all sixteen.
	assign col_hi    = col_sync[1] | col_sync[0];
	assign addr_sync = {col_hi, byte_sync};
	assign selected  = (sel_sync == `BMEM_SEL_ALL);
	// ****************************************
	// Write pulse trailing edge
	// ****************************************
	bmem_edge u_edge (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.pulse_in (write_pulse_in),
		.fall_out (write_fall)
	);
	// ****************************************
	// Storage array
	// ****************************************
	// Contents are reset to zero so simulation never reads unknowns.
	// A write needs the edge, the held select and the held enable at once;
	// anything less leaves every location untouched.
	assign write_go = write_fall & sel_hold & we_hold;

	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_loc
			assign write_hit[i] = write_go && (addr_hold == i);
			always @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					mem[i] <= `BMEM_RESET_DATA;
				end else if (write_hit[i]) begin
					mem[i] <= data_hold;
				end
			end
		end
	endgenerate

	// ****************************************
	// Read path
	// ****************************************
	// Three cycles (24 ns) from pin to output, well under the read budget;
	// a write lands four cycles after the pin's trailing edge, under 165 ns.
	// The output is registered, so readers on a shared line see no glitches.
	always @* begin
		if (selected) begin
			next_data = mem[addr_sync];
		end else begin
			next_data = `BMEM_IDLE_DATA;
		end
	end
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_out <= `BMEM_IDLE_DATA;
		end else begin
			data_out <= next_data;
		end
	end
endmodule // bmem_top
`default_nettype wire

/* File: bench/bmem_monitor.sv */
// Checker for the selectable byte memory
`timescale 1ns/100ps
`default_nettype none
module bmem_monitor #(parameter DATA_W = 8) (
	input wire              clk_in, rst_n_in, write_en_in, write_pulse_in,
	input wire [4:0]        module_sel_in,
	input wire [2:0]        byte_addr_in,
	input wire [1:0]        col_addr_in,
	input wire [DATA_W-1:0] data_in, data_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire sel = module_sel_in == 5'h1f;
	sequence s_wr;
		sel && write_en_in && write_pulse_in ##1
		(sel && write_en_in && !write_pulse_in && $stable({col_addr_in, byte_addr_in, data_in}))[*8];
	endsequence
	property p_wr; s_wr |=> data_out == $past(data_in); endproperty
	a_wr: assert property (p_wr) else $error("byte not read back");
	property p_idle; !sel [*3] |=> data_out == 8'hff; endproperty
	a_idle: assert property (p_idle) else $error("idle output not ones");
	property p_hold; (sel && !write_en_in && $stable({col_addr_in, byte_addr_in}))[*6] |=> $stable(data_out); endproperty
	a_hold: assert property (p_hold) else $error("byte changed unwritten");
	sequence s_wr_off;
		sel && !write_en_in && write_pulse_in ##1
		(sel && !write_en_in && !write_pulse_in && $stable({col_addr_in, byte_addr_in, data_in}))[*8];
	endsequence
	property p_wr_off; s_wr_off |=> $stable(data_out); endproperty
	a_wr_off: assert property (p_wr_off) else $error("disabled write changed byte");
	property p_exit; $fell(sel) |-> ##[1:13] data_out == 8'hff; endproperty
	a_exit: assert property (p_exit) else $error("deselect too slow");
	property p_lat; !sel |-> ##3 data_out == 8'hff; endproperty
	a_lat: assert property (p_lat) else $error("idle latency wrong");
endmodule // bmem_monitor
bind bmem_top bmem_monitor #(.DATA_W(DATA_W)) i_mon (.clk_in(clk_in), .rst_n_in(rst_n_in), .write_en_in(write_en_in),
	.write_pulse_in(write_pulse_in), .module_sel_in(module_sel_in), .byte_addr_in(byte_addr_in),
	.col_addr_in(col_addr_in), .data_in(data_in), .data_out(data_out));
`default_nettype wire

/* File: bench/bmem_host.sv */
// Host model driving the memory's pins
`timescale 1ns/100ps
`default_nettype none
module bmem_host (
	input wire         clk_in,
	output logic [4:0] sel_out,
	output logic [3:0] loc_out,
	output logic [7:0] data_out,
	output logic       we_out,
	output logic       pulse_out
);
	initial {sel_out, loc_out, data_out, we_out, pulse_out} = '0;
	task wr(input [4:0] s, input [3:0] a, input [7:0] d, input e);
		@(posedge clk_in) #1 {sel_out, loc_out, data_out, we_out, pulse_out} = {s, a, d, e, 1'b1};
		repeat (4) @(posedge clk_in);
		#1 pulse_out = 1'b0;
		repeat (9) @(posedge clk_in);
		// Released data is inverted so a stale byte never passes for valid
		#1 {we_out, data_out} = {1'b0, ~d};
	endtask
	task rd(input [4:0] s, input [3:0] a);
		@(posedge clk_in) #1 {sel_out, loc_out} = {s, a};
		repeat (6) @(posedge clk_in);
	endtask
endmodule // bmem_host
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the selectable byte memory
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       clk_in = 0, rst_n_in = 0, we, pulse;
	logic [4:0] sel;
	logic [3:0] loc;
	logic [7:0] din, dout, v, mem [16];
	integer     seed = 22, n_fail = 0, checks_done = 0, cycles = 0, i;
	always #4 clk_in = ~clk_in;
	bmem_host i_bmem_host (.clk_in(clk_in), .sel_out(sel), .loc_out(loc), .data_out(din), .we_out(we), .pulse_out(pulse));
	// Upper column bit held low: only sixteen locations exist
	bmem_top i_bmem_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .module_sel_in(sel), .byte_addr_in(loc[2:0]),
		.col_addr_in({1'b0, loc[3]}), .write_en_in(we), .write_pulse_in(pulse), .data_in(din), .data_out(dout));
	task chk(input [7:0] seen, input [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task rdc(input [4:0] s, input [3:0] a, input [7:0] e);
		i_bmem_host.rd(s, a);
		#1 chk(dout, e);
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			conclude;
		end
	end
	initial begin
		repeat (4) @(posedge clk_in);
		#1 rst_n_in = 1;
		for (i = 0; i < 16; i++) begin
			mem[i] = 8'($random(seed));
			i_bmem_host.wr(5'h1f, i[3:0], mem[i], 1'b1);
		end
		for (i = 0; i < 16; i++) rdc(5'h1f, i[3:0], mem[i]);
		i_bmem_host.wr(5'h1f, 4'h3, ~mem[3], 1'b0);
		rdc(5'h1f, 4'h3, mem[3]);
		for (i = 0; i < 5; i++) begin
			v = 8'($random(seed));
			i_bmem_host.wr(5'h1f ^ (5'h01 << i), 4'h7, v, 1'b1);
			rdc(5'h1f ^ (5'h01 << i), 4'h7, 8'hff);
		end
		rdc(5'h1f, 4'h7, mem[7]);
		conclude;
	end
endmodule // tb
`default_nettype wire
